// File: hw/acps_params.svh
// Purpose: timing and reset constants for the conversion and power sequencer
// Assumes: 200 MHz system clock
// Notes:   counts derive from the printed times
`ifndef ACPS_PARAMS_SVH
`define ACPS_PARAMS_SVH
`define ACPS_CLK_MHZ          200
`define ACPS_NCH              8
`define ACPS_CONV_PER_CH_NS   555
`define ACPS_CONV_OFFSET_NS   35
`define ACPS_CONV_PER_CH_CYC  ((`ACPS_CONV_PER_CH_NS * `ACPS_CLK_MHZ) / 1000)
`define ACPS_CONV_OFFSET_CYC  ((`ACPS_CONV_OFFSET_NS * `ACPS_CLK_MHZ + 999) / 1000)
`define ACPS_INIT_MS          10
`define ACPS_INIT_CYC         (`ACPS_INIT_MS * 1000 * `ACPS_CLK_MHZ)
`define ACPS_RST_MS           1
`define ACPS_RST_CYC          (`ACPS_RST_MS * 1000 * `ACPS_CLK_MHZ)
`define ACPS_RANGE_DEFAULT    24'hffffff
`define ACPS_RANGE_DISABLED   3'h0
`define ACPS_RANGE_W          24
`define ACPS_CODE_W           3
`endif

// File: hw/acps_pkg.sv
// Purpose: types for the conversion and power sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package acps_pkg;
  typedef enum logic [3:0] {
    ST_NAP   = 4'h1,
    ST_CONV  = 4'h2,
    ST_PDOWN = 4'h4,
    ST_RESET = 4'h8
  } acps_state_t;
endpackage

// File: hw/acps_chan_count.sv
// Purpose: count enabled channels and derive the conversion length
// Assumes: range word is from the same clock
// Notes:   output registered
`timescale 1ns/1ps
`default_nettype none
`include "acps_params.svh"
module acps_chan_count #(
  parameter int NCH  = `ACPS_NCH,
  parameter int CW   = 20
) (
  input  wire logic                      clk_sys,   // system clock
  input  wire logic                      sys_rst,   // sync reset
  input  wire logic [NCH*`ACPS_CODE_W-1:0] rangeWord, // per-channel codes
  output logic      [CW-1:0]             convCycles // conversion length
);
  // length of eight channels needs ten bits
  if (NCH < 1 || NCH > 8 || CW < 10)
  begin : g_bad_par
    $error("acps_chan_count: parameters out of range");
  end

  logic [NCH-1:0] chanOn;
  logic [3:0]     nOn;
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_on
      assign chanOn[g] = rangeWord[g*`ACPS_CODE_W +: `ACPS_CODE_W] != `ACPS_RANGE_DISABLED;
    end
  endgenerate

  always_comb
  begin
    nOn = 4'h0;
    for (int i = 0; i < NCH; i++)
      nOn = nOn + {3'h0, chanOn[i]};
  end

  wire [CW-1:0] perCh  = CW'(`ACPS_CONV_PER_CH_CYC);
  wire [CW-1:0] offCyc = CW'(`ACPS_CONV_OFFSET_CYC);
  wire [CW-1:0] prod   = CW'(perCh * CW'(nOn));
  wire [CW-1:0] lenD   = (nOn == 4'h0) ? CW'(1) : CW'(prod - offCyc);

  always_ff @(posedge clk_sys)
    if (sys_rst)
      convCycles <= '0;
    else
      convCycles <= lenD;
endmodule // acps_chan_count
`default_nettype wire

// File: hw/adc_conv_seq.sv
// Purpose: conversion, power-down and global reset sequencing
// Assumes: convert_start and power_down_pin are asynchronous pins
// Notes:   global reset hold time is a parameter
// Behaviour
// - convert-start rise samples all, starts conversion
// - conversion runs to end unless reset
// - busy high for whole conversion
// - conversion at most 555N-35 ns
// - eight channels sustain 200 ksps
// - power-down high ignores conversion requests
// - power-down during conversion waits completion
// - second power-down rise without conversion resets
// - reset clears outputs, range to 7
// - reset halts running conversion
// - power-down still applies on reset edge
// - nap after conversion, wake on start
// - interface-select picks CMOS or LVDS
// - transaction window opens after init, busy fall
// - range code 000 disables channel
// - range register resets to all ones
`timescale 1ns/1ps
`default_nettype none
`include "acps_params.svh"
module adc_conv_seq #(
  parameter int NCH      = `ACPS_NCH,
  parameter int INIT_CYC = `ACPS_INIT_CYC,
  parameter int RST_CYC  = `ACPS_RST_CYC
) (
  input  wire logic                   clk_sys,         // system clock
  input  wire logic                   sys_rst,         // sync reset
  input  wire logic                   convert_start,   // start pin
  input  wire logic                   power_down_pin,  // power-down pin
  input  wire logic                   lvdsSelect,      // interface select pin
  input  wire logic [`ACPS_RANGE_W-1:0] rangeWrData,   // new range word
  input  wire logic                   rangeWrEn,       // range write strobe
  input  wire logic [NCH*18-1:0]      convResult,      // analog core results
  output logic                        busy,            // conversion running
  output logic                        holdSample,      // sample-and-hold in hold
  output logic                        napMode,         // nap state
  output logic                        poweredDown,     // powered down
  output logic                        globalReset,     // global reset active
  output logic                        windowOpen,      // data window open
  output logic                        lvdsMode,        // lvds interface chosen
  output logic [`ACPS_RANGE_W-1:0]    rangeCfg,        // range register
  output logic [NCH*18-1:0]           laneData         // output data registers
);
  if (NCH != 8)
  begin : g_bad_nch
    $error("adc_conv_seq: NCH must be 8");
  end
  if (INIT_CYC < 1 || RST_CYC < 1)
  begin : g_bad_cnt
    $error("adc_conv_seq: bad counts");
  end

  localparam int CW = 20;
  localparam int TW = 32;

  logic cnvS1_q, cnvS2_q, cnvS3_q;
  logic pdS1_q, pdS2_q, pdS3_q;
  logic selS1_q, selS2_q;
  acps_pkg::acps_state_t state_q, state_d;
  logic [CW-1:0] convCnt_q;
  logic [CW-1:0] convCycles;
  logic [TW-1:0] rstCnt_q;
  logic [TW-1:0] initCnt_q;
  logic          pdArmed_q;
  logic          busy_q;
  logic          initDone_q;
  logic          window_q;
  logic [`ACPS_RANGE_W-1:0] range_q;
  logic [NCH*18-1:0] lane_q;

  always_ff @(posedge clk_sys)
    if (sys_rst)
    begin
      {cnvS1_q, cnvS2_q, cnvS3_q} <= 3'h0;
      {pdS1_q, pdS2_q, pdS3_q}    <= 3'h0;
      {selS1_q, selS2_q}          <= 2'h0;
    end
    else
    begin
      {cnvS1_q, cnvS2_q, cnvS3_q} <= {convert_start, cnvS1_q, cnvS2_q};
      {pdS1_q, pdS2_q, pdS3_q}    <= {power_down_pin, pdS1_q, pdS2_q};
      {selS1_q, selS2_q}          <= {lvdsSelect, selS1_q};
    end

  wire cnvRise  = cnvS2_q & ~cnvS3_q;
  wire pdRise   = pdS2_q & ~pdS3_q;
  wire pdLevel  = pdS2_q;
  wire inConv   = state_q == acps_pkg::ST_CONV;
  wire inReset  = state_q == acps_pkg::ST_RESET;
  wire rstFire  = pdRise & pdArmed_q;
  wire startOk  = cnvRise & ~pdLevel & (state_q == acps_pkg::ST_NAP);
  wire convDone = inConv & (convCnt_q == CW'(1));
  wire rstDone  = inReset & (rstCnt_q == TW'(1));

  acps_chan_count #(
    .NCH (NCH),
    .CW  (CW)
  ) u_count (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .rangeWord  (range_q),
    .convCycles (convCycles)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      acps_pkg::ST_NAP:
        if (rstFire)
          state_d = acps_pkg::ST_RESET;
        else if (pdLevel)
          state_d = acps_pkg::ST_PDOWN;
        else if (startOk)
          state_d = acps_pkg::ST_CONV;
      acps_pkg::ST_CONV:
        if (rstFire)
          state_d = acps_pkg::ST_RESET;
        else if (convDone)
          state_d = pdLevel ? acps_pkg::ST_PDOWN : acps_pkg::ST_NAP;
      acps_pkg::ST_PDOWN:
        if (rstFire)
          state_d = acps_pkg::ST_RESET;
        else if (!pdLevel)
          state_d = acps_pkg::ST_NAP;
      acps_pkg::ST_RESET:
        if (rstDone)
          state_d = pdLevel ? acps_pkg::ST_PDOWN : acps_pkg::ST_NAP;
      default:
        state_d = acps_pkg::ST_NAP;
    endcase
  end

  always_ff @(posedge clk_sys)
    if (sys_rst)
      state_q <= acps_pkg::ST_NAP;
    else
      state_q <= state_d;

  always_ff @(posedge clk_sys)
    if (sys_rst)
      convCnt_q <= '0;
    else if (startOk)
      convCnt_q <= convCycles;
    else if (inConv && convCnt_q != '0)
      convCnt_q <= convCnt_q - CW'(1);

  always_ff @(posedge clk_sys)
    if (sys_rst)
      rstCnt_q <= '0;
    else if (rstFire)
      rstCnt_q <= TW'(RST_CYC);
    else if (inReset && rstCnt_q != '0)
      rstCnt_q <= rstCnt_q - TW'(1);

  always_ff @(posedge clk_sys)
    if (sys_rst)
      pdArmed_q <= 1'b0;
    else if (startOk || rstFire)
      pdArmed_q <= 1'b0;
    else if (pdRise)
      pdArmed_q <= 1'b1;

  always_ff @(posedge clk_sys)
    if (sys_rst)
      busy_q <= 1'b0;
    else
      busy_q <= (state_d == acps_pkg::ST_CONV);

  always_ff @(posedge clk_sys)
    if (sys_rst || rstFire)
    begin
      initCnt_q  <= TW'(INIT_CYC);
      initDone_q <= 1'b0;
    end
    else if (initCnt_q != '0)
    begin
      initCnt_q  <= initCnt_q - TW'(1);
      initDone_q <= (initCnt_q == TW'(1));
    end
    else
      initDone_q <= 1'b0;

  always_ff @(posedge clk_sys)
    if (sys_rst || rstFire)
      window_q <= 1'b0;
    else if (startOk)
      window_q <= 1'b0;
    else if (initDone_q || (convDone && !rstFire))
      window_q <= 1'b1;

  always_ff @(posedge clk_sys)
    if (sys_rst || rstFire)
      range_q <= `ACPS_RANGE_DEFAULT;
    else if (rangeWrEn && !inReset)
      range_q <= rangeWrData;

  always_ff @(posedge clk_sys)
    if (sys_rst || rstFire)
      lane_q <= '0;
    else if (convDone)
      lane_q <= convResult;

  assign busy        = busy_q;
  assign holdSample  = busy_q;
  assign napMode     = state_q == acps_pkg::ST_NAP;
  assign poweredDown = state_q == acps_pkg::ST_PDOWN;
  assign globalReset = inReset;
  assign windowOpen  = window_q;
  assign lvdsMode    = selS2_q;
  assign rangeCfg    = range_q;
  assign laneData    = lane_q;
endmodule // adc_conv_seq
`default_nettype wire

// File: testbench/acps_monitor.sv
// Purpose: port checker for adc_conv_seq
// Assumes: one clock, sync reset
// Notes:   bound after the module
`timescale 1ns/1ps
`default_nettype none
module acps_monitor #(parameter int NCH = 8) (
  input wire logic              clk_sys,       // clock
  input wire logic              sys_rst,       // reset
  input wire logic              convert_start, // start pin
  input wire logic              power_down_pin, // power-down pin
  input wire logic              lvdsSelect,    // select pin
  input wire logic              busy,          // converting
  input wire logic              holdSample,    // hold
  input wire logic              napMode,       // nap
  input wire logic              poweredDown,   // power-down
  input wire logic              globalReset,   // reset
  input wire logic              lvdsMode,      // mode
  input wire logic [23:0]       rangeCfg,      // ranges
  input wire logic [NCH*18-1:0] laneData       // lanes
);
  logic [9:0] busyCnt_q;
  // busy cycles of the running conversion
  always_ff @(posedge clk_sys)
  begin
    busyCnt_q <= (sys_rst || !busy) ? 10'h000 : busyCnt_q + 10'h001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_hold_tracks: assert property (holdSample == busy)
    else $error("hold differs from busy");
  chk_start_cause: assert property ($rose(busy) |-> $past(convert_start, 2))
    else $error("busy without start");
  chk_conv_max: assert property (busy |-> busyCnt_q < 10'h371)
    else $error("conversion too long");
  chk_conv_whole: assert property ($fell(busy) |-> busyCnt_q >= 10'h068 || globalReset)
    else $error("conversion cut short");
  chk_reset_halt: assert property (globalReset |=> !busy)
    else $error("busy during reset");
  chk_reset_clear: assert property (globalReset |=> rangeCfg == 24'hffffff && laneData == '0)
    else $error("reset left state");
  chk_pd_refuse: assert property (poweredDown |=> !$rose(busy))
    else $error("start while down");
  chk_pd_block: assert property ($rose(busy) |-> !$past(power_down_pin, 3))
    else $error("start taken while pin high");
  chk_nap_after: assert property ($fell(busy) |-> napMode || poweredDown || globalReset)
    else $error("no nap after end");
  chk_iface_pick: assert property (lvdsMode == $past(lvdsSelect, 2))
    else $error("mode not following pin");
endmodule // acps_monitor
bind adc_conv_seq acps_monitor #(.NCH(NCH)) u_mon (
  .clk_sys        (clk_sys),
  .sys_rst        (sys_rst),
  .convert_start  (convert_start),
  .power_down_pin (power_down_pin),
  .lvdsSelect     (lvdsSelect),
  .busy           (busy),
  .holdSample     (holdSample),
  .napMode        (napMode),
  .poweredDown    (poweredDown),
  .globalReset    (globalReset),
  .lvdsMode       (lvdsMode),
  .rangeCfg       (rangeCfg),
  .laneData       (laneData)
);
`default_nettype wire

// File: testbench/acps_host_model.sv
// Purpose: host driving start and power-down pins
// Assumes: bench clock
// Notes:   pins move 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module acps_host_model #(parameter int SETTLE = 60) (
  input  wire logic clk_sys,        // clock
  output var logic  convert_start,  // start pin
  output var logic  power_down_pin  // power-down pin
);
  initial
  begin
    convert_start = 1'b0;
    power_down_pin = 1'b0;
  end
  task automatic start_conv();
    @(posedge clk_sys) #1 convert_start = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 convert_start = 1'b0;
  endtask
  task automatic set_pd(input logic v);
    @(posedge clk_sys) #1 power_down_pin = v;
    if (!v)
      repeat (SETTLE) @(posedge clk_sys);
  endtask
endmodule // acps_host_model
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: bench for adc_conv_seq
// Assumes: short init and reset counts
// Notes:   pins from acps_host_model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         clk_sys, sys_rst, convert_start, power_down_pin, lvdsSelect, rangeWrEn;
  logic         busy, holdSample, napMode, poweredDown, globalReset, windowOpen, lvdsMode;
  logic [23:0]  rangeWrData, rangeCfg;
  logic [143:0] convResult, laneData;
  int           n_errors = 0;
  int           n_compared = 0;
  int           cycles = 0;
  adc_conv_seq #(
    .INIT_CYC (50),
    .RST_CYC  (40)
  ) dut (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .convert_start  (convert_start),
    .power_down_pin (power_down_pin),
    .lvdsSelect     (lvdsSelect),
    .rangeWrData    (rangeWrData),
    .rangeWrEn      (rangeWrEn),
    .convResult     (convResult),
    .busy           (busy),
    .holdSample     (holdSample),
    .napMode        (napMode),
    .poweredDown    (poweredDown),
    .globalReset    (globalReset),
    .windowOpen     (windowOpen),
    .lvdsMode       (lvdsMode),
    .rangeCfg       (rangeCfg),
    .laneData       (laneData)
  );
  acps_host_model host (
    .clk_sys        (clk_sys),
    .convert_start  (convert_start),
    .power_down_pin (power_down_pin)
  );
  task automatic check(input string what, input logic [143:0] seen, input logic [143:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic write_range(input logic [23:0] w);
    @(posedge clk_sys) #1 rangeWrData = w;
    rangeWrEn = 1'b1;
    tick(1);
    rangeWrEn = 1'b0;
    check("range", rangeCfg, w);
  endtask
  // second start lands mid-conversion; starts stay 30 cycles apart
  task automatic convert(input int exp);
    int n;
    int h;
    n = 0;
    h = 0;
    fork
      host.start_conv();
      begin
        repeat (30) @(posedge clk_sys);
        host.start_conv();
      end
    join_none
    repeat (1000)
    begin
      tick(1);
      if (busy === 1'b1)
        n++;
      if (holdSample === 1'b1)
        h++;
    end
    check("busy cycles", n, exp);
    check("hold cycles", h, exp);
    check("mode", lvdsMode, lvdsSelect);
    check("lanes", laneData, convResult);
    check("window", windowOpen, 1'b1);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    lvdsSelect = 1'b0;
    rangeWrData = 24'h000000;
    rangeWrEn = 1'b0;
    convResult = 144'h0;
    tick(2);
    sys_rst = 1'b0;
    check("range", rangeCfg, 24'hffffff);
    check("nap", napMode, 1'b1);
    tick(60);
    check("window", windowOpen, 1'b1);
    for (int k = 1; k <= 8; k++)
    begin
      lvdsSelect = k[0];
      convResult = {8{18'(k * 4099)}};
      write_range(24'hffffff >> (24 - 3 * k));
      convert(111 * k - 7);
    end
    write_range(24'h000fff);
    fork
      begin
        repeat (50) @(posedge clk_sys);
        host.set_pd(1'b1);
      end
    join_none
    convert(437);
    check("down", poweredDown, 1'b1);
    convert(0);
    host.set_pd(1'b0);
    host.set_pd(1'b1);
    tick(6);
    check("reset", globalReset, 1'b1);
    check("range", rangeCfg, 24'hffffff);
    check("lanes", laneData, 144'h0);
    tick(50);
    check("down", poweredDown, 1'b1);
    host.set_pd(1'b0);
    fork
      host.start_conv();
    join_none
    tick(40);
    host.set_pd(1'b1);
    host.set_pd(1'b0);
    host.set_pd(1'b1);
    tick(8);
    check("busy", busy, 1'b0);
    host.set_pd(1'b0);
    convert(881);
    host.set_pd(1'b1);
    host.set_pd(1'b0);
    convert(881);
    host.set_pd(1'b1);
    tick(8);
    check("reset", globalReset, 1'b0);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
